// ---- common/pit_pkg.sv ----
// Shared constants for the preset interval timer unit
package pit_pkg;

   // ----------------------------------------
   // Clock and tick base
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam longint CENTI_TICK_NS = 64'h0000_0000_0098_9680;
   localparam int CENTI_TICK_CYCLES = int'(CENTI_TICK_NS / CLK_PERIOD_NS);
   localparam int TICK_CNT_W = 18;
   localparam logic [3:0] CENTI_PER_DECI_LAST = 4'h9;

   // ----------------------------------------
   // Register bus geometry
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_TIMERS = 4;
   localparam int NUM_SLOTS = 6;

   // ----------------------------------------
   // Offsets
   // ----------------------------------------
   localparam logic [7:0] CUR_BASE = 8'h00;
   localparam logic [7:0] PRESET_BASE = 8'h10;
   localparam logic [7:0] PRESET_SEL_ADDR = 8'h20;
   localparam logic [7:0] STATUS_ADDR = 8'h21;
   localparam logic [7:0] TICK_CTRL_ADDR = 8'h22;

   // ----------------------------------------
   // Slot numbers of the four timers
   // ----------------------------------------
   localparam logic [2:0] SLOT_DECI_HOLD = 3'h0;
   localparam logic [2:0] SLOT_CENTI_HOLD = 3'h1;
   localparam logic [2:0] SLOT_DECI_ACC = 3'h2;
   localparam logic [2:0] SLOT_CENTI_ACC = 3'h4;

   // ----------------------------------------
   // Limits and reset values, packed BCD
   // ----------------------------------------
   localparam logic [31:0] HOLD_MAX = 32'h0000_9999;
   localparam logic [31:0] ACC_MAX = 32'h9999_9999;
   localparam logic [31:0] CONST_PRESET_DEFAULT = 32'h0000_0030;
   localparam logic [15:0] PRESET_WORD_RST = 16'h0000;
   localparam logic [3:0] PRESET_SEL_RST = 4'h0;
   localparam logic TICK_RUN_RST = 1'b1;

endpackage

// ---- rtl/pit_channel.sv ----
// One preset-compare timer channel with BCD count and saturation
`timescale 1ns/10ps
module pit_channel
#(
   parameter logic [31:0] MAX_VALUE = 32'h0000_9999
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic run,
   input wire logic clear,
   input wire logic [31:0] preset,
   output logic [31:0] value,
   output logic status
);
   import pit_pkg::*;

   logic [31:0] next_value;

   // ----------------------------------------
   // Packed BCD increment over eight digits
   // ----------------------------------------
   function automatic logic [31:0] bcd_inc(input logic [31:0] v);
      logic [31:0] r;
      logic carry;
      r = v;
      carry = 1'b1;
      for (int d = 0; d < 8; d++)
      begin
         if (carry)
         begin
            if (v[d*4 +: 4] == 4'h9)
            begin
               r[d*4 +: 4] = 4'h0;
            end
            else
            begin
               r[d*4 +: 4] = v[d*4 +: 4] + 4'h1;
               carry = 1'b0;
            end
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // Count
   // ----------------------------------------
   always_comb
   begin
      next_value = value;
      if (clear)
      begin
         next_value = 32'h0000_0000;
      end
      else if (run && tick && value != MAX_VALUE)
      begin
         next_value = bcd_inc(value);
      end
      // Stays put at the ceiling until cleared
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         value <= 32'h0000_0000;
      end
      else
      begin
         value <= next_value;
      end
   end

   // ----------------------------------------
   // Status: packed BCD orders like binary
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         status <= 1'b0;
      end
      else
      begin
         status <= !clear && (next_value >= preset);
      end
   end

endmodule

// ---- rtl/pit_top.sv ----
// Preset interval timer unit: tick base, four timers and register port
// Functional notes
// - Hold timer counts each tick while input on
// - Hold input dropping clears value and status
// - Decisecond hold timer tops at 999.9 s
// - Centisecond hold timer tops at 99.99 s
// - Status set when value reaches preset
// - Accumulating timer freezes while enable off
// - Re-enable resumes from frozen value
// - Reset input clears accumulated value
// - Held cleared while reset stays on
// - Decisecond accumulator tops at 9999999.9 s
// - Centisecond accumulator tops at 999999.99 s
// - Accumulator holds eight digits in two slots
// - Current value read at its slot word
// - Preset from constant or writable word
`timescale 1ns/10ps
module pit_top
#(
   parameter int CENTI_CYCLES = pit_pkg::CENTI_TICK_CYCLES,
   parameter logic [31:0] CONST_PRESET_0 = pit_pkg::CONST_PRESET_DEFAULT,
   parameter logic [31:0] CONST_PRESET_1 = pit_pkg::CONST_PRESET_DEFAULT,
   parameter logic [31:0] CONST_PRESET_2 = pit_pkg::CONST_PRESET_DEFAULT,
   parameter logic [31:0] CONST_PRESET_3 = pit_pkg::CONST_PRESET_DEFAULT
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [pit_pkg::ADDR_W-1:0] addr,
   input wire logic [pit_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [pit_pkg::DATA_W-1:0] rdata,
   input wire logic [1:0] hold_in,
   input wire logic [1:0] acc_enable,
   input wire logic [1:0] acc_reset,
   output logic [pit_pkg::NUM_TIMERS-1:0] timer_status,
   output logic centi_tick,
   output logic deci_tick
);
   import pit_pkg::*;

   localparam logic [TICK_CNT_W-1:0] CENTI_LAST = TICK_CNT_W'(CENTI_CYCLES - 1);

   logic [TICK_CNT_W-1:0] centi_cnt;
   logic [3:0] deci_cnt;
   logic tick_run;
   logic [15:0] preset_word [NUM_SLOTS];
   logic [3:0] preset_sel;
   logic [31:0] cur_value [NUM_TIMERS];
   logic [31:0] word_preset [NUM_TIMERS];
   logic [31:0] preset_use [NUM_TIMERS];
   logic [31:0] const_preset [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] t_tick;
   logic [NUM_TIMERS-1:0] t_run;
   logic [NUM_TIMERS-1:0] t_clear;
   logic [DATA_W-1:0] next_rdata;

   // ----------------------------------------
   // Address decode helpers
   // ----------------------------------------
   function automatic logic in_window(input logic [7:0] a, input logic [7:0] base);
      return (a >= base) && (a < base + 8'(NUM_SLOTS));
   endfunction

   function automatic logic [2:0] slot_of(input logic [7:0] a, input logic [7:0] base);
      logic [7:0] off;
      off = a - base;
      return off[2:0];
   endfunction

   // ----------------------------------------
   // Tick base
   // ----------------------------------------
   // Counting halts while tick_run is low, which lets software freeze
   // every timer at once; the dividers restart on a clean boundary.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         centi_cnt <= '0;
         centi_tick <= 1'b0;
      end
      else if (!tick_run)
      begin
         centi_cnt <= '0;
         centi_tick <= 1'b0;
      end
      else if (centi_cnt == CENTI_LAST)
      begin
         centi_cnt <= '0;
         centi_tick <= 1'b1;
      end
      else
      begin
         centi_cnt <= centi_cnt + 1'b1;
         centi_tick <= 1'b0;
      end
   end

   // Deci tick follows every tenth centi tick one clock later, so both bases stay in step
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         deci_cnt <= 4'h0;
         deci_tick <= 1'b0;
      end
      else if (!tick_run)
      begin
         deci_cnt <= 4'h0;
         deci_tick <= 1'b0;
      end
      else if (centi_tick)
      begin
         deci_tick <= (deci_cnt == CENTI_PER_DECI_LAST);
         deci_cnt <= (deci_cnt == CENTI_PER_DECI_LAST) ? 4'h0 : deci_cnt + 4'h1;
      end
      else
      begin
         deci_tick <= 1'b0;
      end
   end

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------
   // Writes to read-only or unmapped words are dropped without a trace
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_SLOTS; i++)
         begin
            preset_word[i] <= PRESET_WORD_RST;
         end
      end
      else if (wr && in_window(addr, PRESET_BASE))
      begin
         preset_word[slot_of(addr, PRESET_BASE)] <= wdata;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         preset_sel <= PRESET_SEL_RST;
      end
      else if (wr && addr == PRESET_SEL_ADDR)
      begin
         preset_sel <= wdata[3:0];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tick_run <= TICK_RUN_RST;
      end
      // Resets high so the timers run without any setup
      else if (wr && addr == TICK_CTRL_ADDR)
      begin
         tick_run <= wdata[0];
      end
   end

   // ----------------------------------------
   // Preset sources
   // ----------------------------------------
   // Fixed presets come from parameters, one per timer
   always_comb
   begin
      const_preset[0] = CONST_PRESET_0;
      const_preset[1] = CONST_PRESET_1;
      const_preset[2] = CONST_PRESET_2;
      const_preset[3] = CONST_PRESET_3;
   end

   // Accumulators take two adjacent words, low digits first. A new
   // preset applies at once, so software should stop an accumulator
   // before it rewrites both halves of its preset.
   always_comb
   begin
      word_preset[0] = {16'h0000, preset_word[SLOT_DECI_HOLD]};
      word_preset[1] = {16'h0000, preset_word[SLOT_CENTI_HOLD]};
      word_preset[2] = {preset_word[SLOT_DECI_ACC + 3'h1], preset_word[SLOT_DECI_ACC]};
      word_preset[3] = {preset_word[SLOT_CENTI_ACC + 3'h1], preset_word[SLOT_CENTI_ACC]};
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
         preset_use[i] = preset_sel[i] ? word_preset[i] : const_preset[i];
      end
   end

   // ----------------------------------------
   // Timer controls
   // ----------------------------------------
   // Deciseconds drive timers 0 and 2, centiseconds timers 1 and 3
   always_comb
   begin
      t_tick[0] = deci_tick;
      t_tick[1] = centi_tick;
      t_tick[2] = deci_tick;
      t_tick[3] = centi_tick;
   end

   // Program logic shares this clock, so its inputs need no synchroniser.
   // A hold input both runs its timer and, once low, clears it; on an
   // accumulator, reset wins over enable so a held timer stays at zero.
   always_comb
   begin
      t_run[0] = hold_in[0];
      t_run[1] = hold_in[1];
      t_clear[0] = !hold_in[0];
      t_clear[1] = !hold_in[1];
      t_run[2] = acc_enable[0] && !acc_reset[0];
      t_run[3] = acc_enable[1] && !acc_reset[1];
      t_clear[2] = acc_reset[0];
      t_clear[3] = acc_reset[1];
   end

   // ----------------------------------------
   // Timer channels
   // ----------------------------------------
   generate
      for (genvar g = 0; g < NUM_TIMERS; g++)
      begin : g_timer
         pit_channel
         #(
            .MAX_VALUE((g < 2) ? HOLD_MAX : ACC_MAX)
         )
         u_channel
         (
            .clk(clk),
            .rst(rst),
            .tick(t_tick[g]),
            .run(t_run[g]),
            .clear(t_clear[g]),
            .preset(preset_use[g]),
            .value(cur_value[g]),
            .status(timer_status[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Each current value sits at the word whose index is its slot number;
   // an accumulator's high digits follow in the next word
   function automatic logic [15:0] value_word(input logic [2:0] slot);
      logic [15:0] w;
      case (slot)
         3'h0: w = cur_value[0][15:0];
         3'h1: w = cur_value[1][15:0];
         3'h2: w = cur_value[2][15:0];
         3'h3: w = cur_value[2][31:16];
         3'h4: w = cur_value[3][15:0];
         3'h5: w = cur_value[3][31:16];
         default: w = 16'h0000;
      endcase
      return w;
   endfunction

   // Unmapped words read as zero, so software may probe the map safely
   always_comb
   begin
      next_rdata = 16'h0000;
      if (in_window(addr, CUR_BASE))
      begin
         next_rdata = value_word(slot_of(addr, CUR_BASE));
      end
      else if (in_window(addr, PRESET_BASE))
      begin
         next_rdata = preset_word[slot_of(addr, PRESET_BASE)];
      end
      else if (addr == PRESET_SEL_ADDR)
      begin
         next_rdata = {12'h000, preset_sel};
      end
      else if (addr == STATUS_ADDR)
      begin
         next_rdata = {12'h000, timer_status};
      end
      else if (addr == TICK_CTRL_ADDR)
      begin
         next_rdata = {15'h0000, tick_run};
      end
   end

   // Data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata <= 16'h0000;
      end
      else
      begin
         rdata <= rd ? next_rdata : 16'h0000;
      end
   end

endmodule

// ---- testbench/pit_program.sv ----
// Control program model driving the timers' hold, enable and reset inputs
`timescale 1ns/10ps
module pit_program
(
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [5:0] want,
   output logic [1:0] hold_in,
   output logic [1:0] acc_enable,
   output logic [1:0] acc_reset
);
   logic [1:0] scan;
   // A slow program pass refreshes its outputs only every fourth clock
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scan <= 2'h0;
         {acc_reset, acc_enable, hold_in} <= 6'h00;
      end
      else
      begin
         scan <= scan + 2'h1;
         // Both accumulators and both hold timers get their inputs from want at once
         if (!slow || scan == 2'h0)
            {acc_reset, acc_enable, hold_in} <= want;
      end
   end
endmodule

// ---- testbench/pit_checker.sv ----
// Port assertions for the timer unit
`timescale 1ns/10ps
module pit_checker
#(
   parameter int CENTI_CYCLES = 4
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rd,
   input wire logic wr,
   input wire logic [15:0] rdata,
   input wire logic [1:0] hold_in,
   input wire logic [1:0] acc_enable,
   input wire logic [1:0] acc_reset,
   input wire logic [3:0] timer_status,
   input wire logic centi_tick,
   input wire logic deci_tick
);
   localparam int DECI = 10 * CENTI_CYCLES;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ------
   // Checks
   // ------
   rd_idle_zero_a: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("rdata set without read");
   hold0_clear_a: assert property (!hold_in[0] |=> !timer_status[0])
      else $error("hold 0 status not cleared");
   hold1_clear_a: assert property (!hold_in[1] |=> !timer_status[1])
      else $error("hold 1 status not cleared");
   acc_held_a: assert property ((timer_status[3:2] & $past(acc_reset)) == 2'h0)
      else $error("status during reset");
   tick_pulse_a: assert property (centi_tick |=> !centi_tick)
      else $error("tick too long");
   tick_period_a: assert property (centi_tick |-> ##CENTI_CYCLES centi_tick)
      else $error("tick period wrong");
   deci_follow_a: assert property (deci_tick |-> $past(centi_tick))
      else $error("deci tick unaligned");
   deci_period_a: assert property (deci_tick |-> ##DECI deci_tick)
      else $error("deci period wrong");
   hold_status_cause_a: assert property ($rose(timer_status[0]) |->
      ($past(deci_tick) && $past(hold_in[0])) || $past(wr, 2) || !$past(hold_in[0], 2))
      else $error("hold status rose alone");
   acc_freeze_a: assert property ($rose(timer_status[2]) |->
      ($past(acc_enable[0]) && $past(deci_tick)) || $past(wr, 2) || $past(acc_reset[0], 2))
      else $error("frozen timer moved");
   acc_keep_a: assert property ($fell(timer_status[2]) |-> $past(acc_reset[0]) || $past(wr, 2))
      else $error("accumulated status lost");
endmodule
bind pit_top pit_checker #(.CENTI_CYCLES(CENTI_CYCLES)) checks (.clk(clk), .rst(rst), .rd(rd),
   .wr(wr), .rdata(rdata), .hold_in(hold_in), .acc_enable(acc_enable), .acc_reset(acc_reset),
   .timer_status(timer_status), .centi_tick(centi_tick), .deci_tick(deci_tick));

// ---- testbench/preset_interval_timer_bench.sv ----
// Self-checking bench for the preset interval timer unit
`timescale 1ns/10ps
module preset_interval_timer_bench;
   import pit_pkg::*;
   localparam logic [31:0] CP [4] = '{32'h30, 32'h25, 32'h45, 32'h120};
   localparam int CENTI = 4;
   logic clk, rst, wr, rd, slow, centi_tick, deci_tick, rd_pend;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, exp_rd;
   logic [5:0] want;
   logic [1:0] hold_in, acc_enable, acc_reset;
   logic [3:0] timer_status, sel, st, clrv, runv, tkv;
   logic [31:0] val [4];
   logic [15:0] pw [6];
   int n_errors = 0;
   int comparisons = 0;
   int mcc, mdc;
   logic mct, mdt;
   pit_top #(.CENTI_CYCLES(CENTI), .CONST_PRESET_0(CP[0]), .CONST_PRESET_1(CP[1]),
      .CONST_PRESET_2(CP[2]), .CONST_PRESET_3(CP[3])) dut (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hold_in(hold_in), .acc_enable(acc_enable),
      .acc_reset(acc_reset), .timer_status(timer_status), .centi_tick(centi_tick),
      .deci_tick(deci_tick));
   pit_program prog (.clk(clk), .rst(rst), .slow(slow), .want(want), .hold_in(hold_in),
      .acc_enable(acc_enable), .acc_reset(acc_reset));
   // ---------------
   // Reference model
   // ---------------
   function automatic logic [31:0] bcd_inc(logic [31:0] v, logic [31:0] m);
      logic [31:0] r;
      logic [3:0] d;
      logic c;
      r = v;
      c = (v != m); // Saturate rather than wrap
      for (int i = 0; i < 8; i++)
      begin
         d = r[4*i+:4];
         r[4*i+:4] = !c ? d : (d == 4'h9) ? 4'h0 : d + 4'h1;
         c = c && (d == 4'h9);
      end
      return r;
   endfunction
   function automatic logic [31:0] preset(int i);
      logic [31:0] w;
      w = i < 2 ? {16'h0000, pw[i]} : {pw[2*i-1], pw[2*i-2]};
      return sel[i] ? w : CP[i];
   endfunction
   function automatic logic [15:0] reg_rd(logic [7:0] a);
      logic [31:0] v;
      v = val[a < 8'h02 ? a[1:0] : a < 8'h04 ? 2'h2 : 2'h3];
      if (a < 8'h06)
         return (a == 8'h03 || a == 8'h05) ? v[31:16] : v[15:0];
      if (a >= PRESET_BASE && a < PRESET_BASE + 8'h06)
         return pw[a - PRESET_BASE];
      if (a == PRESET_SEL_ADDR || a == STATUS_ADDR)
         return {12'h000, a == STATUS_ADDR ? st : sel};
      return {15'h0000, a == TICK_CTRL_ADDR && TICK_RUN_RST};
   endfunction
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         val = '{default: 32'h0};
         pw = '{default: 16'h0};
         sel = 4'h0;
         st = 4'h0;
         rd_pend = 1'b0;
         mcc = 0;
         mdc = 0;
         mct = 1'b0;
         mdt = 1'b0;
      end
      else
      begin
         rd_pend = rd;
         exp_rd = reg_rd(addr);
         clrv = {acc_reset, ~hold_in};
         runv = {acc_enable, hold_in};
         tkv = {mct, mdt, mct, mdt};
         for (int i = 0; i < 4; i++)
         begin
            val[i] = clrv[i] ? 32'h0 : (tkv[i] && runv[i]) ?
               bcd_inc(val[i], i < 2 ? HOLD_MAX : ACC_MAX) : val[i];
            st[i] = !clrv[i] && val[i] >= preset(i);
         end
         if (wr && addr >= PRESET_BASE && addr < PRESET_BASE + 8'h06)
            pw[addr - PRESET_BASE] = wdata;
         if (wr && addr == PRESET_SEL_ADDR)
            sel = wdata[3:0];
         // Own tick base: a centi pulse every CENTI clocks, deci on every tenth
         mdt = mct && mdc == int'(CENTI_PER_DECI_LAST);
         if (mct)
            mdc = (mdc == int'(CENTI_PER_DECI_LAST)) ? 0 : mdc + 1;
         mct = mcc == CENTI - 1;
         mcc = (mcc == CENTI - 1) ? 0 : mcc + 1;
      end
   end
   always @(negedge clk)
   begin
      if (!rst)
      begin
         check_status(st, timer_status);
         check_tick({mct, mdt}, {centi_tick, deci_tick});
      end
      if (!rst && rd_pend)
         check_word(exp_rd, rdata);
   end
   // -------------
   // Bench helpers
   // -------------
   task automatic check_word(logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error at %0t: word expected %h got %h", $time, e, g);
      end
   endtask
   task automatic check_status(logic [3:0] e, logic [3:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error at %0t: status expected %h got %h", $time, e, g);
      end
   endtask
   task automatic check_tick(logic [1:0] e, logic [1:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error at %0t: ticks expected %h got %h", $time, e, g);
      end
   endtask
   task automatic bus(logic w, logic r, logic [7:0] a, logic [15:0] d);
      @(posedge clk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      #3000000;
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      logic [31:0] r;
      {rst, wr, rd, slow, addr, wdata, want} = {4'h8, 8'h00, 16'h0000, 6'h00};
      r = $urandom(32'h86B30458);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 48; a++) bus(1'b0, 1'b1, 8'(a), 16'h0000);
      bus(1'b1, 1'b0, 8'h00, 16'h1234);
      bus(1'b1, 1'b0, STATUS_ADDR, 16'h000F);
      bus(1'b1, 1'b0, PRESET_BASE + 8'h02, 16'h0004);
      bus(1'b1, 1'b0, PRESET_SEL_ADDR, 16'h0004);
      bus(1'b1, 1'b0, TICK_CTRL_ADDR, 16'h0001);
      for (int a = 0; a < 48; a++) bus(1'b0, 1'b1, 8'(a), 16'h0000);
      $display("test registers done");
      // On, off, on, reset while enabled, on: the frozen count must carry over
      for (int k = 0; k < 5; k++)
      begin
         want <= k == 1 ? 6'h00 : k == 3 ? 6'h14 : 6'h04;
         repeat (100) bus(1'b0, 1'b1, 8'h02, 16'h0000);
      end
      $display("test accumulate done");
      for (int k = 0; k < 6000; k++)
      begin
         r = $urandom();
         if (r[15:8] == 8'h00)
            {slow, want} <= r[6:0];
         case (r[17:16])
            2'h0: bus(1'b0, 1'b0, 8'h00, 16'h0000);
            2'h1: bus(1'b1, 1'b0, PRESET_BASE + 8'(r[22:20] % 6), {12'h000, 4'(r[27:24] % 10)});
            2'h2: bus(1'b1, 1'b0, PRESET_SEL_ADDR, {12'h000, r[31:28]});
            default: bus(1'b0, 1'b1, 8'(r[29:24] % 36), 16'h0000);
         endcase
      end
      $display("test random done");
      {slow, want} <= 7'h0A;
      repeat (40100) bus(1'b0, 1'b0, 8'h00, 16'h0000);
      for (int a = 0; a < 6; a++) bus(1'b0, 1'b1, 8'(a), 16'h0000);
      want <= 6'h00;
      repeat (4) bus(1'b0, 1'b0, 8'h00, 16'h0000);
      for (int a = 0; a < 6; a++) bus(1'b0, 1'b1, 8'(a), 16'h0000);
      bus(1'b0, 1'b0, 8'h00, 16'h0000);
      $display("test saturation done");
      report_and_stop();
   end
endmodule
